// [core/iep_pkg.sv]
// package: register map, field positions, reset values and timing for the irq enable/priority bank
package iep_pkg;

	localparam int          IEP_NUM_SRC       = 7;
	localparam logic [11:0] IEP_ADDR_ENABLE   = 12'h0a8;
	localparam logic [11:0] IEP_ADDR_PRIO     = 12'h0ac;
	localparam logic [11:0] IEP_ADDR_PENDING  = 12'h0c0;
	localparam logic [11:0] IEP_ADDR_STATUS   = 12'h0c4;
	localparam logic [11:0] IEP_ADDR_CONTROL  = 12'h0c8;
	localparam logic [7:0]  IEP_ENABLE_RESET  = 8'h00;
	localparam logic [7:0]  IEP_PRIO_RESET    = 8'h80;
	localparam int          IEP_GLOBAL_BIT    = 7;
	localparam int          IEP_PRIO_FIXED    = 7;
	localparam int          IEP_SRC_EXT0      = 0;
	localparam int          IEP_SRC_TMR0      = 1;
	localparam int          IEP_SRC_EXT1      = 2;
	localparam int          IEP_SRC_TMR1      = 3;
	localparam int          IEP_SRC_UART      = 4;
	localparam int          IEP_SRC_TMR2      = 5;
	localparam int          IEP_SRC_SPI       = 6;
	localparam int          IEP_DETECT_CYC    = 1;
	localparam int          IEP_CALL_CYC      = 4;
	localparam int          IEP_RESPONSE_CYC  = IEP_DETECT_CYC + IEP_CALL_CYC;
	localparam logic [2:0]  IEP_CALL_LAST     = 3'(IEP_CALL_CYC - 1);

	typedef enum logic [1:0] {
		IEP_LVL_NONE,
		IEP_LVL_LOW,
		IEP_LVL_HIGH
	} iep_level_t;

	// index of lowest set bit; fixed source order within one level
	function automatic logic [2:0] iep_first(input logic [6:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = IEP_NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : iep_first

endpackage : iep_pkg

// [core/iep_pending.sv]
// pending flag bank: hardware sets, software sets or clears, vectoring clears
`timescale 1ns/1ns
`default_nettype none
module iep_pending
	import iep_pkg::*;
#(
	parameter int N = 7
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// event sources
	input  wire logic [N-1:0] hw_set,
	// software access
	input  wire logic         sw_wr,
	input  wire logic [N-1:0] sw_data,
	// vectoring acknowledge
	input  wire logic [N-1:0] ack_clr,
	// flags
	output logic      [N-1:0] pend_q
);

	logic [N-1:0] pend_d;

	// hardware set beats any clear in the same cycle
	always_comb begin
		pend_d = pend_q & ~ack_clr;
		if (sw_wr) begin
			pend_d = sw_data & ~ack_clr;
		end
		pend_d = pend_d | hw_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= '0;
		end else begin
			pend_q <= pend_d;
		end
	end

endmodule : iep_pending
`default_nettype wire

// [core/iep_arbiter.sv]
// two-level priority pick of the gated requests
`timescale 1ns/1ns
`default_nettype none
module iep_arbiter
	import iep_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// gated requests and levels
	input  wire logic [6:0] req,
	input  wire logic [6:0] prio,
	// registered choice
	output logic            sel_valid_q,
	output logic            sel_high_q,
	output logic [2:0]      sel_idx_q
);

	logic [6:0] hi_req;

	assign hi_req = req & prio;

	// high level first, then fixed order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_valid_q <= 1'b0;
			sel_high_q  <= 1'b0;
			sel_idx_q   <= 3'h0;
		end else begin
			sel_valid_q <= |req;
			sel_high_q  <= |hi_req;
			sel_idx_q   <= (|hi_req) ? iep_first(hi_req) : iep_first(req);
		end
	end

endmodule : iep_arbiter
`default_nettype wire

// [core/iep_top.sv]
// interrupt enable and priority bank with apb slave, pending flags and call sequencer
//
// Behaviour
// - global enable bit 7 blocks all requests
// - global on: forward only individually masked-in sources
// - enable bit 6 masks serial peripheral
// - enable bit 5 masks timer two, either overflow
// - enable bit 4 masks uart
// - enable bit 3 masks timer one overflow
// - enable bit 2 masks external input one
// - enable bit 1 masks timer zero overflow
// - enable bit 0 masks external input zero
// - enable register at 0xa8, resets zero
// - priority bit 6: serial peripheral level
// - priority bit 4: uart level
// - priority bit 3: timer one level
// - priority bit 2: external one level
// - high preempts low; high never preempted
// - simultaneous: higher level first, then fixed order
// - decode each cycle; response five cycles minimum
// - software-set pending flag requests like hardware
`timescale 1ns/1ns
`default_nettype none
module iep_top
	import iep_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt sources, active high one-cycle events
	input  wire logic        ext_irq_zero_input,
	input  wire logic        timer_zero_overflow,
	input  wire logic        ext_irq_one_input,
	input  wire logic        timer_one_overflow,
	input  wire logic        uart_event,
	input  wire logic        timer_two_low_overflow,
	input  wire logic        timer_two_high_overflow,
	input  wire logic        serial_periph_event,
	// cpu side
	output logic             irq_call,
	output logic [2:0]       irq_vector,
	output logic             irq_in_service_high,
	output logic             irq_in_service_low
);

	////////////////////////////////////////////////////////////////////////////////
	// registers and decode

	logic [7:0] interrupt_enable_mask_q;
	logic [6:0] prio_bits_q;
	logic [7:0] interrupt_priority_select;
	logic [6:0] pend_q;
	logic [6:0] hw_set;
	logic [6:0] ack_clr;
	logic [6:0] req;
	logic [6:0] masked_pend;
	logic       global_irq_enable;
	logic       apb_access;
	logic       wr_en;
	logic       wr_enable_reg;
	logic       wr_prio_reg;
	logic       wr_pend_reg;
	logic       wr_ctrl_reg;
	logic       mapped;
	logic       sel_valid_q;
	logic       sel_high_q;
	logic [2:0] sel_idx_q;

	assign apb_access    = psel && penable && pready;
	assign wr_en         = apb_access && pwrite;
	assign wr_enable_reg = wr_en && (paddr == IEP_ADDR_ENABLE);
	assign wr_prio_reg   = wr_en && (paddr == IEP_ADDR_PRIO);
	assign wr_pend_reg   = wr_en && (paddr == IEP_ADDR_PENDING);
	assign wr_ctrl_reg   = wr_en && (paddr == IEP_ADDR_CONTROL);
	assign mapped        = (paddr == IEP_ADDR_ENABLE) || (paddr == IEP_ADDR_PRIO)
	                    || (paddr == IEP_ADDR_PENDING) || (paddr == IEP_ADDR_STATUS)
	                    || (paddr == IEP_ADDR_CONTROL);

	// bit 7 fixed at one
	assign interrupt_priority_select = {1'b1, prio_bits_q};
	assign global_irq_enable         = interrupt_enable_mask_q[IEP_GLOBAL_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable_mask_q <= IEP_ENABLE_RESET;
		end else if (wr_enable_reg) begin
			interrupt_enable_mask_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prio_bits_q <= IEP_PRIO_RESET[6:0];
		end else if (wr_prio_reg) begin
			// bits 6..0 each pick low or high; bit 7 write dropped
			prio_bits_q <= pwdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pending flags and gating

	always_comb begin
		hw_set               = '0;
		hw_set[IEP_SRC_EXT0] = ext_irq_zero_input;
		hw_set[IEP_SRC_TMR0] = timer_zero_overflow;
		hw_set[IEP_SRC_EXT1] = ext_irq_one_input;
		hw_set[IEP_SRC_TMR1] = timer_one_overflow;
		hw_set[IEP_SRC_UART] = uart_event;
		hw_set[IEP_SRC_TMR2] = timer_two_low_overflow | timer_two_high_overflow;
		hw_set[IEP_SRC_SPI]  = serial_periph_event;
	end

	// software write of pending register loads the flags: ones request like hardware, zeros clear
	iep_pending #(
		.N (IEP_NUM_SRC)
	) u_pending (
		.pclk    (pclk),
		.presetn (presetn),
		.hw_set  (hw_set),
		.sw_wr   (wr_pend_reg),
		.sw_data (pwdata[6:0]),
		.ack_clr (ack_clr),
		.pend_q  (pend_q)
	);

	// global gate over per-source masks
	assign masked_pend = pend_q & interrupt_enable_mask_q[6:0];
	assign req         = global_irq_enable ? masked_pend : 7'h00;

	iep_arbiter u_arbiter (
		.pclk        (pclk),
		.presetn     (presetn),
		.req         (req),
		.prio        (prio_bits_q),
		.sel_valid_q (sel_valid_q),
		.sel_high_q  (sel_high_q),
		.sel_idx_q   (sel_idx_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// call sequencer and nesting

	logic       calling_q;
	logic [2:0] call_cnt_q;
	logic [2:0] call_idx_q;
	logic       call_high_q;
	logic       may_take;
	logic       ret_high;
	logic       ret_low;

	// low service can be preempted by high only; high service by nothing
	assign may_take = sel_valid_q && !calling_q && !irq_in_service_high
	               && (!irq_in_service_low || sel_high_q);
	assign ret_high = wr_ctrl_reg && pwdata[0] && irq_in_service_high;
	assign ret_low  = wr_ctrl_reg && pwdata[0] && !irq_in_service_high && irq_in_service_low;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calling_q   <= 1'b0;
			call_cnt_q  <= 3'h0;
			call_idx_q  <= 3'h0;
			call_high_q <= 1'b0;
		end else if (may_take) begin
			calling_q   <= 1'b1;
			call_cnt_q  <= 3'h0;
			call_idx_q  <= sel_idx_q;
			call_high_q <= sel_high_q;
		end else if (calling_q) begin
			call_cnt_q <= call_cnt_q + 3'h1;
			if (call_cnt_q == IEP_CALL_LAST) begin
				calling_q <= 1'b0;
			end
		end
	end

	logic call_done;
	assign call_done = calling_q && (call_cnt_q == IEP_CALL_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_call   <= 1'b0;
			irq_vector <= 3'h0;
		end else begin
			irq_call   <= call_done;
			irq_vector <= call_done ? call_idx_q : irq_vector;
		end
	end

	// vectoring clears the serviced flag
	always_comb begin
		ack_clr = '0;
		if (call_done) begin
			ack_clr[call_idx_q] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_in_service_high <= 1'b0;
		end else if (call_done && call_high_q) begin
			irq_in_service_high <= 1'b1;
		end else if (ret_high) begin
			irq_in_service_high <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_in_service_low <= 1'b0;
		end else if (call_done && !call_high_q) begin
			irq_in_service_low <= 1'b1;
		end else if (ret_low) begin
			irq_in_service_low <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb read and response

	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			IEP_ADDR_ENABLE:  rd_mux[7:0] = interrupt_enable_mask_q;
			IEP_ADDR_PRIO:    rd_mux[7:0] = interrupt_priority_select;
			IEP_ADDR_PENDING: rd_mux[6:0] = pend_q;
			IEP_ADDR_STATUS:  rd_mux[7:0] = {irq_in_service_high, irq_in_service_low,
			                                 calling_q, sel_valid_q, sel_high_q, sel_idx_q};
			default:          rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= !mapped;
		end else begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	AST_GLOBAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!global_irq_enable |-> req == 7'h00)
		else $error("request passed with global enable off");

	AST_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
		(req & ~interrupt_enable_mask_q[6:0]) == 7'h00)
		else $error("masked source forwarded");

	AST_FORWARD: assert property (@(posedge pclk) disable iff (!presetn)
		global_irq_enable && (pend_q & interrupt_enable_mask_q[6:0]) != 7'h00 |=> sel_valid_q)
		else $error("enabled pending source not forwarded");

	AST_SPI_MASK: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_enable_mask_q[IEP_SRC_SPI] |-> !req[IEP_SRC_SPI])
		else $error("serial peripheral request passed its mask");

	AST_TMR2_MASK: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_enable_mask_q[IEP_SRC_TMR2] |-> !req[IEP_SRC_TMR2])
		else $error("timer two request passed its mask");

	AST_TMR2_EITHER: assert property (@(posedge pclk) disable iff (!presetn)
		timer_two_low_overflow || timer_two_high_overflow |=> pend_q[IEP_SRC_TMR2])
		else $error("timer two overflow not pending");

	AST_UART_MASK: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_enable_mask_q[IEP_SRC_UART] |-> !req[IEP_SRC_UART])
		else $error("uart request passed its mask");

	AST_TMR1_MASK: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_enable_mask_q[IEP_SRC_TMR1] |-> !req[IEP_SRC_TMR1])
		else $error("timer one request passed its mask");

	AST_EXT1_MASK: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_enable_mask_q[IEP_SRC_EXT1] |-> !req[IEP_SRC_EXT1])
		else $error("external one request passed its mask");

	AST_TMR0_MASK: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_enable_mask_q[IEP_SRC_TMR0] |-> !req[IEP_SRC_TMR0])
		else $error("timer zero request passed its mask");

	AST_EXT0_MASK: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_enable_mask_q[IEP_SRC_EXT0] |-> !req[IEP_SRC_EXT0])
		else $error("external zero request passed its mask");

	AST_ENABLE_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_enable_reg |=> interrupt_enable_mask_q == $past(pwdata[7:0]))
		else $error("enable register write lost");

	AST_PRIO_TOP: assert property (@(posedge pclk) disable iff (!presetn)
		interrupt_priority_select[IEP_PRIO_FIXED])
		else $error("priority bit 7 not one");

	AST_PRIO_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_prio_reg |=> prio_bits_q == $past(pwdata[6:0]))
		else $error("priority write lost");

	AST_HIGH_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		|(req & prio_bits_q) |=> sel_high_q && prio_bits_q[sel_idx_q] || $changed(prio_bits_q))
		else $error("low source picked over high");

	AST_NO_PREEMPT_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		irq_in_service_high && !ret_high |=> !calling_q || $past(calling_q))
		else $error("high service preempted");

	AST_NO_PREEMPT_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		irq_in_service_low && !ret_low && !sel_high_q |=> !calling_q || $past(calling_q))
		else $error("low service preempted by low source");

	AST_RESPONSE: assert property (@(posedge pclk) disable iff (!presetn)
		may_take |=> calling_q [*4] ##1 irq_call)
		else $error("call timing wrong");

	AST_CALL_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		irq_call |=> !irq_call)
		else $error("call pulse longer than one cycle");

	AST_SW_SET: assert property (@(posedge pclk) disable iff (!presetn)
		wr_pend_reg && !call_done |=> pend_q == ($past(pwdata[6:0]) | $past(hw_set)))
		else $error("software pending write lost");

endmodule : iep_top
`default_nettype wire

// [verification/iep_core_model.sv]
// processor core model: apb master that reaches the enable and priority bank
`timescale 1ns/1ns
`default_nettype none
module iep_core_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one transfer; request held until pready is sampled high, then scrambled
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask : xfer
endmodule : iep_core_model
`default_nettype wire

// [verification/irq_enable_priority_regs_test.sv]
// self-checking bench for the irq enable and priority bank
`timescale 1ns/1ns
`default_nettype none
module irq_enable_priority_regs_test
	import iep_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rq;
	logic [7:0]  ev;
	logic        irq_call, ins_hi, ins_lo, re;
	logic [2:0]  irq_vector;
	int          miscompares = 0;
	int          checks_done = 0;

	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	iep_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_irq_zero_input(ev[0]),
		.timer_zero_overflow(ev[1]), .ext_irq_one_input(ev[2]),
		.timer_one_overflow(ev[3]), .uart_event(ev[4]), .timer_two_low_overflow(ev[5]),
		.serial_periph_event(ev[6]), .timer_two_high_overflow(ev[7]),
		.irq_call(irq_call), .irq_vector(irq_vector),
		.irq_in_service_high(ins_hi), .irq_in_service_low(ins_lo));

	iep_core_model u_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_core.xfer(1'b1, a, d, rq, re);
		chk("write pslverr", 32'h0000_0000, {31'h0, re});
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
		u_core.xfer(1'b0, a, 32'h0000_0000, rq, re);
		chk("read data", exp, rq);
		chk("read pslverr", {31'h0, err}, {31'h0, re});
	endtask : rd

	task automatic pulse(input logic [7:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= 8'h00;
	endtask : pulse

	// irq_call expected within a bounded span, never sooner than the response time
	task automatic call(input logic [2:0] v, input logic hi);
		int n;
		n = 0;
		while (irq_call !== 1'b1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		chk("call latency", 32'h0000_0001, {31'h0, n >= IEP_RESPONSE_CYC && n < 40});
		chk("irq_vector", {29'h0, v}, {29'h0, irq_vector});
		chk("in service high", {31'h0, hi}, {31'h0, ins_hi});
	endtask : call

	task automatic none();
		logic seen;
		seen = 1'b0;
		repeat (20) begin
			@(negedge pclk);
			if (irq_call !== 1'b0) seen = 1'b1;
		end
		chk("irq_call absent", 32'h0000_0000, {31'h0, seen});
	endtask : none

	task automatic ret();
		wr(IEP_ADDR_CONTROL, 32'h0000_0001);
	endtask : ret

	task automatic results();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10000) @(posedge pclk);
		miscompares++;
		results();
	end

	initial begin
		presetn = 1'b0;
		ev      = 8'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(IEP_ADDR_ENABLE, 32'h0000_0000, 1'b0);
		rd(IEP_ADDR_PRIO, 32'h0000_0080, 1'b0);
		wr(IEP_ADDR_PRIO, 32'h0000_0000);
		rd(IEP_ADDR_PRIO, 32'h0000_0080, 1'b0);
		wr(IEP_ADDR_PRIO, 32'h0000_007f);
		rd(IEP_ADDR_PRIO, 32'h0000_00ff, 1'b0);
		wr(IEP_ADDR_ENABLE, 32'h0000_00ff);
		rd(IEP_ADDR_ENABLE, 32'h0000_00ff, 1'b0);
		rd(12'hffc, 32'h0000_0000, 1'b1);
		$display("test registers done");
		wr(IEP_ADDR_PRIO, 32'h0000_0000);
		wr(IEP_ADDR_ENABLE, 32'h0000_007f);
		pulse(8'hff);
		none();
		wr(IEP_ADDR_PENDING, 32'h0000_0000);
		$display("test global enable done");
		for (int i = 0; i < 7; i++) begin
			wr(IEP_ADDR_ENABLE, 32'h0000_0080 | (32'h1 << i));
			pulse(~(8'h01 << i) & ((i == 5) ? 8'h5f : 8'hff));
			none();
			wr(IEP_ADDR_PENDING, 32'h0000_0000);
			pulse((i == 5) ? 8'h80 : (8'h01 << i));
			call(3'(i), 1'b0);
			ret();
		end
		wr(IEP_ADDR_ENABLE, 32'h0000_00a0);
		pulse(8'h20);
		call(3'h5, 1'b0);
		ret();
		$display("test masks done");
		wr(IEP_ADDR_ENABLE, 32'h0000_00ff);
		wr(IEP_ADDR_PRIO, 32'h0000_0010);
		pulse(8'h11);
		call(3'h4, 1'b1);
		ret();
		call(3'h0, 1'b0);
		ret();
		pulse(8'h0c);
		call(3'h2, 1'b0);
		ret();
		call(3'h3, 1'b0);
		ret();
		$display("test arbitration done");
		pulse(8'h01);
		call(3'h0, 1'b0);
		pulse(8'h10);
		call(3'h4, 1'b1);
		chk("in service low", 32'h0000_0001, {31'h0, ins_lo});
		pulse(8'h02);
		none();
		ret();
		none();
		ret();
		call(3'h1, 1'b0);
		ret();
		$display("test preemption done");
		wr(IEP_ADDR_ENABLE, 32'h0000_0088);
		wr(IEP_ADDR_PENDING, 32'h0000_0008);
		call(3'h3, 1'b0);
		ret();
		$display("test software pending done");
		results();
	end
endmodule : irq_enable_priority_regs_test
`default_nettype wire
